// *** common/lcs_pkg.sv ***
// constants, field layouts and carrier types of the lcd command and parameter interpreter
// assumes an 8-bit host port with a command/data select line and active-low strobes
package lcs_pkg;

	// command codes taken on a command write
	localparam logic [7:0] CMD_SYS_SETUP = 8'h40;	// system setup, eight parameters
	localparam logic [7:0] CMD_SCROLL    = 8'h44;	// screen block setup, ten parameters
	localparam logic [7:0] CMD_HSHIFT    = 8'h5a;	// horizontal pixel shift, one parameter
	localparam logic [7:0] CMD_OVERLAY   = 8'h5b;	// layer combine, one parameter

	// register offsets in the internal configuration file
	localparam logic [4:0] REG_SYSTEM_CONFIG      = 5'h00;
	localparam logic [4:0] REG_CHAR_WIDTH_DRIVE   = 5'h01;
	localparam logic [4:0] REG_CHAR_HEIGHT_CFG    = 5'h02;
	localparam logic [4:0] REG_LINE_ADDRESS_COUNT = 5'h03;
	localparam logic [4:0] REG_LINE_TOTAL_COUNT   = 5'h04;
	localparam logic [4:0] REG_FRAME_LINE_COUNT   = 5'h05;
	localparam logic [4:0] REG_VIRTUAL_PITCH_LOW  = 5'h06;
	localparam logic [4:0] REG_VIRTUAL_PITCH_HIGH = 5'h07;
	localparam logic [4:0] REG_BLOCK1_START_LOW   = 5'h0b;
	localparam logic [4:0] REG_BLOCK1_START_HIGH  = 5'h0c;
	localparam logic [4:0] REG_BLOCK1_LINE_COUNT  = 5'h0d;
	localparam logic [4:0] REG_BLOCK2_START_LOW   = 5'h0e;
	localparam logic [4:0] REG_BLOCK2_START_HIGH  = 5'h0f;
	localparam logic [4:0] REG_BLOCK2_LINE_COUNT  = 5'h10;
	localparam logic [4:0] REG_BLOCK3_START_LOW   = 5'h11;
	localparam logic [4:0] REG_BLOCK3_START_HIGH  = 5'h12;
	localparam logic [4:0] REG_BLOCK4_START_LOW   = 5'h13;
	localparam logic [4:0] REG_BLOCK4_START_HIGH  = 5'h14;
	localparam logic [4:0] REG_LAYER_OVERLAY_CFG  = 5'h18;
	localparam logic [4:0] REG_PIXEL_HSHIFT       = 5'h1b;

	// parameter counts of each command group
	localparam logic [3:0] SYS_PARAM_COUNT    = 4'h8;
	localparam logic [3:0] SCROLL_PARAM_COUNT = 4'ha;
	localparam logic [3:0] SINGLE_PARAM_COUNT = 4'h1;

	// field positions
	localparam int CFG_ROM_BIT      = 0;
	localparam int CFG_HEIGHT_BIT   = 2;
	localparam int CFG_PANEL_BIT    = 3;
	localparam int CFG_TOPLINE_BIT  = 5;
	localparam int DRIVE_AC_BIT     = 7;
	localparam int OVL_BLOCK1_BIT   = 2;
	localparam int OVL_BLOCK3_BIT   = 3;

	// reset value of every configuration byte
	localparam logic [7:0] REG_RESET = 8'h00;

	// host pins as sampled, idle level of the strobes high
	typedef struct packed {
		logic       cmdDataSelect;	// high marks a command write or a data read
		logic       rdN;			// read strobe, active low
		logic       wrN;			// write strobe, active low
		logic [7:0] data;			// host data bus
	} lcs_host_t;
	localparam lcs_host_t HOST_IDLE = '{cmdDataSelect: 1'b0, rdN: 1'b1, wrN: 1'b1, data: 8'h00};

	// system setup fields, raw and plus-one
	typedef struct packed {
		logic        charRomSelect;
		logic        charHeightMode;
		logic        twoPanelDrive;
		logic        topLineComp;
		logic [3:0]  charCellWidth;
		logic        acDriveMode;
		logic [3:0]  charCellHeight;
		logic [7:0]  lineAddressCount;
		logic [7:0]  lineTotalCount;
		logic [7:0]  frameLineCount;
		logic [15:0] virtualLinePitch;
		logic [4:0]  cellWidthPix;
		logic [4:0]  cellHeightPix;
		logic [8:0]  lineAddrs;
		logic [8:0]  frameLines;
	} lcs_sys_cfg_t;

	// screen block, shift and overlay fields
	typedef struct packed {
		logic [15:0] block1Start;
		logic [7:0]  block1Lines;
		logic [15:0] block2Start;
		logic [7:0]  block2Lines;
		logic [15:0] block3Start;
		logic [15:0] block4Start;
		logic [2:0]  pixelHshift;
		logic [1:0]  combineMethod;
		logic        block1TextSelect;
		logic        block3TextSelect;
	} lcs_scroll_cfg_t;

	// host port sequencing, gray along idle-write-idle and idle-read-idle
	typedef enum logic [1:0] {
		PORT_IDLE  = 2'b00,
		PORT_WRITE = 2'b01,
		PORT_READ  = 2'b10
	} lcs_port_t;

	// command group currently taking parameters
	typedef enum logic [2:0] {
		GRP_NONE    = 3'b000,
		GRP_SYS     = 3'b001,
		GRP_SCROLL  = 3'b011,
		GRP_HSHIFT  = 3'b010,
		GRP_OVERLAY = 3'b110
	} lcs_group_t;

endpackage : lcs_pkg

// *** src/lcs_pin_sync.sv ***
// three-stage synchroniser for asynchronous host pins
// assumes one clock; output follows once stages two and three agree
module lcs_pin_sync #(
	parameter int               WIDTH     = 11,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] syncIn,
	output logic      [WIDTH-1:0] syncOut
);

	if (WIDTH < 1)
	begin : g_bad_width
		$error("lcs_pin_sync width must be positive");
	end

	for (genvar b = 0; b < WIDTH; b++)
	begin : g_bit
		logic [2:0] stage;	// stage[0] read only by stage[1]

		// three flops per bit
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
				stage <= {3{RESET_VAL[b]}};
			else if (ce)
				stage <= {stage[1:0], syncIn[b]};
		end

		// accept a level once the two later stages agree
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
				syncOut[b] <= RESET_VAL[b];
			else if (ce && (stage[1] == stage[2]))
				syncOut[b] <= stage[2];
		end
	end

endmodule : lcs_pin_sync

// *** src/lcs_reg_file.sv ***
// flip-flop configuration file, one byte per entry, written by index
// assumes one writer on the same clock
module lcs_reg_file
	import lcs_pkg::*;
#(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8,
	parameter int IDXW  = $clog2(DEPTH)
) (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   we,
	input  wire logic [IDXW-1:0]        idx,
	input  wire logic [WIDTH-1:0]       wdata,
	output logic      [DEPTH*WIDTH-1:0] regs
);

	if (DEPTH < 2 || WIDTH != 8)
	begin : g_bad_shape
		$error("lcs_reg_file needs byte entries and depth above one");
	end

	for (genvar e = 0; e < DEPTH; e++)
	begin : g_entry
		// one byte, loaded when its index is written
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
				regs[e*WIDTH +: WIDTH] <= REG_RESET;
			else if (ce && we && (idx == IDXW'(e)))
				regs[e*WIDTH +: WIDTH] <= wdata;
		end
	end

endmodule : lcs_reg_file

// *** src/lcs_cmd_param.sv ***
// command and parameter interpreter of the lcd controller host port
// assumes asynchronous host pins and a display-read source on mclk
module lcs_cmd_param
	import lcs_pkg::*;
#(
	parameter int REG_DEPTH = 32
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  cmdDataSelect,
	input  wire logic                  hostRdN,
	input  wire logic                  hostWrN,
	input  wire logic [7:0]            hostDataIn,
	output logic      [7:0]            hostDataOut,
	output logic                       hostDataOeN,
	input  wire logic [7:0]            displayReadData,
	output logic      [7:0]            activeCmd,
	output lcs_pkg::lcs_sys_cfg_t      sysCfg,
	output lcs_pkg::lcs_scroll_cfg_t   scrollCfg
);
	import lcs_pkg::*;

	localparam int IDXW = $clog2(REG_DEPTH);

	// the file must hold the highest offset
	if (REG_DEPTH <= int'(REG_PIXEL_HSHIFT) || REG_DEPTH > 256)
	begin : g_bad_depth
		$error("lcs_cmd_param register depth cannot hold the map");
	end

	lcs_host_t                  rawPins;		// pins as they arrive
	lcs_host_t                  syncPins;		// pins after agreement
	lcs_port_t                  portState;		// host strobe tracker
	lcs_port_t                  next_portState;
	logic                       hostWrite;		// one cycle per write strobe
	lcs_group_t                 curGroup;		// group taking parameters
	logic [3:0]                 paramIndex;		// next parameter position
	logic                       regWe;			// parameter store strobe
	logic [IDXW-1:0]            regIdx;			// store target
	logic [REG_DEPTH*8-1:0]     regs;			// whole file, flat
	logic [7:0]                 regByte [REG_DEPTH];	// file seen as bytes, so fields can be sliced

	assign rawPins = '{cmdDataSelect: cmdDataSelect, rdN: hostRdN, wrN: hostWrN, data: hostDataIn};

	// group to its first register
	function automatic logic [4:0] groupBase(input lcs_group_t g);
		case (g)
			GRP_SYS:     groupBase = REG_SYSTEM_CONFIG;
			GRP_SCROLL:  groupBase = REG_BLOCK1_START_LOW;
			GRP_HSHIFT:  groupBase = REG_PIXEL_HSHIFT;
			GRP_OVERLAY: groupBase = REG_LAYER_OVERLAY_CFG;
			default:     groupBase = 5'h00;
		endcase
	endfunction : groupBase

	// group to its parameter count
	function automatic logic [3:0] groupCount(input lcs_group_t g);
		case (g)
			GRP_SYS:     groupCount = SYS_PARAM_COUNT;
			GRP_SCROLL:  groupCount = SCROLL_PARAM_COUNT;
			GRP_HSHIFT:  groupCount = SINGLE_PARAM_COUNT;
			GRP_OVERLAY: groupCount = SINGLE_PARAM_COUNT;
			default:     groupCount = 4'h0;
		endcase
	endfunction : groupCount

	// byte view of the flat file; a function result cannot take a bit select
	for (genvar e = 0; e < REG_DEPTH; e++)
	begin : g_byte
		assign regByte[e] = regs[e*8 +: 8];
	end

	// all host pins cross through three flops
	lcs_pin_sync #(
		.WIDTH     ($bits(lcs_host_t)),
		.RESET_VAL (HOST_IDLE)
	) u_sync (
		.mclk    (mclk),
		.rst     (rst),
		.ce      (ce),
		.syncIn  (rawPins),
		.syncOut (syncPins)
	);

	// strobe tracking, write wins if both strobes fall together
	always_comb
	begin
		next_portState = portState;
		case (portState)
			PORT_IDLE:
			begin
				if (!syncPins.wrN)
					next_portState = PORT_WRITE;
				else if (!syncPins.rdN)
					next_portState = PORT_READ;
			end
			PORT_WRITE:
			begin
				if (syncPins.wrN)
					next_portState = PORT_IDLE;
			end
			PORT_READ:
			begin
				if (syncPins.rdN)
					next_portState = PORT_IDLE;
			end
			default:
				next_portState = PORT_IDLE;
		endcase
	end

	// strobe state register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			portState <= PORT_IDLE;
		else if (ce)
			portState <= next_portState;
	end

	// a write is taken once, at the falling strobe
	assign hostWrite = (portState == PORT_IDLE) && !syncPins.wrN;

	// command decode, select high marks a command byte
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			curGroup  <= GRP_NONE;
			activeCmd <= 8'h00;
		end
		else if (ce && hostWrite && syncPins.cmdDataSelect)
		begin
			activeCmd <= syncPins.data;
			case (syncPins.data)
				CMD_SYS_SETUP: curGroup <= GRP_SYS;
				CMD_SCROLL:    curGroup <= GRP_SCROLL;
				CMD_HSHIFT:    curGroup <= GRP_HSHIFT;
				CMD_OVERLAY:   curGroup <= GRP_OVERLAY;
				default:       curGroup <= GRP_NONE;	// other commands, not ours
			endcase
		end
	end

	// parameter position, restarts at each command
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			paramIndex <= 4'h0;
		else if (ce && hostWrite)
		begin
			if (syncPins.cmdDataSelect)
				paramIndex <= 4'h0;
			else if (regWe)
				paramIndex <= paramIndex + 4'h1;
		end
	end

	// store strobe; surplus bytes are dropped
	always_comb
	begin
		regWe  = ce && hostWrite && !syncPins.cmdDataSelect
			&& (curGroup != GRP_NONE) && (paramIndex < groupCount(curGroup));
		regIdx = IDXW'(groupBase(curGroup) + 5'(paramIndex));
	end

	// configuration bytes
	lcs_reg_file #(
		.DEPTH (REG_DEPTH),
		.WIDTH (8)
	) u_regs (
		.mclk  (mclk),
		.rst   (rst),
		.ce    (ce),
		.we    (regWe),
		.idx   (regIdx),
		.wdata (syncPins.data),
		.regs  (regs)
	);

	// system setup fields, plus-one counts beside the raw fields
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sysCfg <= '0;
		else if (ce)
		begin
			sysCfg.charRomSelect    <= regByte[REG_SYSTEM_CONFIG][CFG_ROM_BIT];
			sysCfg.charHeightMode   <= regByte[REG_SYSTEM_CONFIG][CFG_HEIGHT_BIT];
			sysCfg.twoPanelDrive    <= regByte[REG_SYSTEM_CONFIG][CFG_PANEL_BIT];
			sysCfg.topLineComp      <= regByte[REG_SYSTEM_CONFIG][CFG_TOPLINE_BIT];
			sysCfg.charCellWidth    <= regByte[REG_CHAR_WIDTH_DRIVE][3:0];
			sysCfg.acDriveMode      <= regByte[REG_CHAR_WIDTH_DRIVE][DRIVE_AC_BIT];
			sysCfg.charCellHeight   <= regByte[REG_CHAR_HEIGHT_CFG][3:0];
			sysCfg.lineAddressCount <= regByte[REG_LINE_ADDRESS_COUNT];
			sysCfg.lineTotalCount   <= regByte[REG_LINE_TOTAL_COUNT];
			sysCfg.frameLineCount   <= regByte[REG_FRAME_LINE_COUNT];
			sysCfg.virtualLinePitch <= {regByte[REG_VIRTUAL_PITCH_HIGH],
				regByte[REG_VIRTUAL_PITCH_LOW]};
			// bracketed quantities
			sysCfg.cellWidthPix     <= {1'b0, regByte[REG_CHAR_WIDTH_DRIVE][3:0]} + 5'h01;
			sysCfg.cellHeightPix    <= {1'b0, regByte[REG_CHAR_HEIGHT_CFG][3:0]} + 5'h01;
			sysCfg.lineAddrs        <= {1'b0, regByte[REG_LINE_ADDRESS_COUNT]} + 9'h001;
			sysCfg.frameLines       <= {1'b0, regByte[REG_FRAME_LINE_COUNT]} + 9'h001;
		end
	end

	// screen blocks, pixel shift and overlay fields
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			scrollCfg <= '0;
		else if (ce)
		begin
			scrollCfg.block1Start      <= {regByte[REG_BLOCK1_START_HIGH],
				regByte[REG_BLOCK1_START_LOW]};
			scrollCfg.block1Lines      <= regByte[REG_BLOCK1_LINE_COUNT];
			scrollCfg.block2Start      <= {regByte[REG_BLOCK2_START_HIGH],
				regByte[REG_BLOCK2_START_LOW]};
			scrollCfg.block2Lines      <= regByte[REG_BLOCK2_LINE_COUNT];
			scrollCfg.block3Start      <= {regByte[REG_BLOCK3_START_HIGH],
				regByte[REG_BLOCK3_START_LOW]};
			scrollCfg.block4Start      <= {regByte[REG_BLOCK4_START_HIGH],
				regByte[REG_BLOCK4_START_LOW]};
			scrollCfg.pixelHshift      <= regByte[REG_PIXEL_HSHIFT][2:0];
			scrollCfg.combineMethod    <= regByte[REG_LAYER_OVERLAY_CFG][1:0];
			scrollCfg.block1TextSelect <= regByte[REG_LAYER_OVERLAY_CFG][OVL_BLOCK1_BIT];
			scrollCfg.block3TextSelect <= regByte[REG_LAYER_OVERLAY_CFG][OVL_BLOCK3_BIT];
		end
	end

	// read path: select high returns display data; oe low while driving
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			hostDataOut <= 8'h00;
			hostDataOeN <= 1'b1;
		end
		else if (ce)
		begin
			if (next_portState == PORT_READ && syncPins.cmdDataSelect)
			begin
				hostDataOut <= displayReadData;
				hostDataOeN <= 1'b0;
			end
			else
				hostDataOeN <= 1'b1;	// release bus
		end
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sys_cmd_decode_a: assert property (ce && hostWrite && syncPins.cmdDataSelect && syncPins.data == CMD_SYS_SETUP
		|=> curGroup == GRP_SYS && paramIndex == 4'h0) else $error("system setup not decoded");

	scroll_cmd_decode_a: assert property (ce && hostWrite && syncPins.cmdDataSelect && syncPins.data == CMD_SCROLL
		|=> curGroup == GRP_SCROLL) else $error("scroll setup not decoded");

	hshift_store_a: assert property ((ce && regWe && curGroup == GRP_HSHIFT) ##1 ce ##1 ce
		|-> scrollCfg.pixelHshift == $past(syncPins.data[2:0], 2)) else $error("pixel shift not stored");

	overlay_method_a: assert property ((ce && regWe && curGroup == GRP_OVERLAY) ##1 ce ##1 ce
		|-> scrollCfg.combineMethod == $past(syncPins.data[1:0], 2)) else $error("combine method not stored");

	overlay_text_a: assert property ((ce && regWe && curGroup == GRP_OVERLAY) ##1 ce ##1 ce
		|-> scrollCfg.block3TextSelect == $past(syncPins.data[3], 2)) else $error("block three select wrong");

	width_plus_one_a: assert property ((ce && regWe && curGroup == GRP_SYS && paramIndex == 4'h1) ##1 ce ##1 ce
		|-> sysCfg.cellWidthPix == {1'b0, $past(syncPins.data[3:0], 2)} + 5'h01) else $error("cell width wrong");

	pitch_high_a: assert property ((ce && regWe && curGroup == GRP_SYS && paramIndex == 4'h7) ##1 ce ##1 ce
		|-> sysCfg.virtualLinePitch[15:8] == $past(syncPins.data, 2)) else $error("pitch high byte wrong");

	param_order_a: assert property (regWe |=> paramIndex == $past(paramIndex) + 4'h1)
		else $error("parameter position not advanced");

	read_drive_a: assert property (ce && portState == PORT_READ && syncPins.cmdDataSelect && !syncPins.rdN
		|=> !hostDataOeN) else $error("read not driven");

endmodule : lcs_cmd_param

// *** testbench/lcs_host_model.sv ***
// host processor model on the 8-bit parallel port of the interpreter
// assumes the design synchronises the pins, so every strobe phase lasts at least HOLD clocks
module lcs_host_model (
	input  wire logic          mclk,
	input  wire logic [7:0]    hostDataOut,
	input  wire logic          hostDataOeN,
	output lcs_pkg::lcs_host_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import lcs_pkg::*;

	localparam int HOLD = 5;	// strobe low and high time, above the three-flop agreement

	// strobes idle high until the first transfer
	initial pins = HOST_IDLE;

	// one byte write; the data is held through the strobe and its synchronised rise
	task automatic host_write(input logic sel, input logic [7:0] value);
		pins.cmdDataSelect <= sel;
		pins.data          <= value;
		pins.wrN           <= 1'b0;
		repeat (HOLD) @(posedge mclk);
		pins.wrN <= 1'b1;
		repeat (3) @(posedge mclk);
		pins.data <= ~value;	// released bus shows the inverse, not a stale value
		repeat (HOLD - 3) @(posedge mclk);
	endtask : host_write

	// one byte read; reports whether the device drove the bus and what it drove
	task automatic host_read(input logic sel, output logic [7:0] value, output logic driven);
		driven = 1'b0;
		value  = 8'h00;
		pins.cmdDataSelect <= sel;
		pins.rdN           <= 1'b0;
		// drive starts one edge after the synchronised strobe, so hold two edges longer
		repeat (HOLD + 2)
		begin
			@(posedge mclk);
			if (hostDataOeN === 1'b0)
			begin
				driven = 1'b1;
				value  = hostDataOut;
			end
		end
		pins.rdN <= 1'b1;
		repeat (HOLD) @(posedge mclk);
	endtask : host_read

endmodule : lcs_host_model

// *** testbench/testbench.sv ***
// self-checking bench of the command and parameter interpreter
// assumes the host model drives the pins and display data is a fixed pattern
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import lcs_pkg::*;

	// one host write and the active command it should leave
	typedef struct packed
	{
		logic       sel;
		logic [7:0] data;
		logic [7:0] expCmd;
	} lcs_row_t;

	localparam int TIMEOUT = 3000;	// about six times the expected run

	// setup in host order: system, scroll, pixel shift, overlay
	localparam lcs_row_t ROWS [24] = '{
		'{1, 8'h40, 8'h40}, '{0, 8'h25, 8'h40}, '{0, 8'h87, 8'h40}, '{0, 8'h07, 8'h40},
		'{0, 8'h3f, 8'h40}, '{0, 8'h49, 8'h40}, '{0, 8'h7f, 8'h40}, '{0, 8'h80, 8'h40},
		'{0, 8'h00, 8'h40}, '{1, 8'h44, 8'h44}, '{0, 8'h34, 8'h44}, '{0, 8'h12, 8'h44},
		'{0, 8'h40, 8'h44}, '{0, 8'h00, 8'h44}, '{0, 8'h10, 8'h44}, '{0, 8'h40, 8'h44},
		'{0, 8'h00, 8'h44}, '{0, 8'h04, 8'h44}, '{0, 8'h00, 8'h44}, '{0, 8'h30, 8'h44},
		'{1, 8'h5a, 8'h5a}, '{0, 8'h0d, 8'h5a}, '{1, 8'h5b, 8'h5b}, '{0, 8'h05, 8'h5b}
	};

	logic            mclk;				// design clock
	logic            rst;				// design reset
	logic            ce;				// design clock enable
	logic [7:0]      displayReadData;	// read source pattern
	lcs_host_t       pins;				// host pins from the model
	logic [7:0]      hostDataOut;		// device bus drive
	logic            hostDataOeN;		// device bus enable
	logic [7:0]      activeCmd;			// last command taken
	lcs_sys_cfg_t    sysCfg;			// system fields
	lcs_scroll_cfg_t scrollCfg;			// block and overlay fields
	logic [7:0]      readValue;			// byte seen by a read
	logic            readDriven;		// bus was driven during a read
	int              nErrors;			// mismatches
	int              samplesChecked;	// comparisons
	int              cycles;			// hang guard

	lcs_cmd_param #(.REG_DEPTH(32)) lcs_cmd_param_inst (
		.mclk            (mclk),
		.rst             (rst),
		.ce              (ce),
		.cmdDataSelect   (pins.cmdDataSelect),
		.hostRdN         (pins.rdN),
		.hostWrN         (pins.wrN),
		.hostDataIn      (pins.data),
		.hostDataOut     (hostDataOut),
		.hostDataOeN     (hostDataOeN),
		.displayReadData (displayReadData),
		.activeCmd       (activeCmd),
		.sysCfg          (sysCfg),
		.scrollCfg       (scrollCfg)
	);

	lcs_host_model lcs_host_model_inst (
		.mclk        (mclk),
		.hostDataOut (hostDataOut),
		.hostDataOeN (hostDataOeN),
		.pins        (pins)
	);

	// free-running clock, 40 ns period
	always #20 mclk = ~mclk;

	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// field comparison
	task automatic check_val(input string name, input logic [15:0] expected, input logic [15:0] seen);
		samplesChecked++;
		if (seen !== expected)
		begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", name, expected, seen);
		end
	endtask : check_val

	// whole configuration comparison
	task automatic check_wide(input string name, input logic [127:0] expected, input logic [127:0] seen);
		samplesChecked++;
		if (seen !== expected)
		begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", name, expected, seen);
		end
	endtask : check_wide

	// hang guard
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT)
		begin
			nErrors++;
			report_and_stop();
		end
	end

	// main sequence
	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		displayReadData = 8'ha5;
		nErrors = 0;
		samplesChecked = 0;
		cycles = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (ROWS[i])
		begin
			lcs_host_model_inst.host_write(ROWS[i].sel, ROWS[i].data);
			check_val("activeCmd", ROWS[i].expCmd, activeCmd);
		end
		check_val("romSel", 1, sysCfg.charRomSelect);
		check_val("heightMode", 1, sysCfg.charHeightMode);
		check_val("twoPanel", 0, sysCfg.twoPanelDrive);
		check_val("topLine", 1, sysCfg.topLineComp);
		check_val("cellWidth", 7, sysCfg.charCellWidth);
		check_val("acDrive", 1, sysCfg.acDriveMode);
		check_val("cellHeight", 7, sysCfg.charCellHeight);
		check_val("widthPix", 8, sysCfg.cellWidthPix);
		check_val("heightPix", 8, sysCfg.cellHeightPix);
		check_val("lineAddrCnt", 16'h3f, sysCfg.lineAddressCount);
		check_val("lineAddrs", 64, sysCfg.lineAddrs);
		check_val("lineTotal", 16'h49, sysCfg.lineTotalCount);
		check_val("frameLineCnt", 16'h7f, sysCfg.frameLineCount);
		check_val("frameLines", 128, sysCfg.frameLines);
		check_val("pitch", 16'h0080, sysCfg.virtualLinePitch);
		check_val("blk1Start", 16'h1234, scrollCfg.block1Start);
		check_val("blk1Lines", 16'h40, scrollCfg.block1Lines);
		check_val("blk2Start", 16'h1000, scrollCfg.block2Start);
		check_val("blk2Lines", 16'h40, scrollCfg.block2Lines);
		check_val("blk3Start", 16'h0400, scrollCfg.block3Start);
		check_val("blk4Start", 16'h3000, scrollCfg.block4Start);
		check_val("hshift", 5, scrollCfg.pixelHshift);
		check_val("combine", 1, scrollCfg.combineMethod);
		check_val("blk1Text", 1, scrollCfg.block1TextSelect);
		check_val("blk3Text", 0, scrollCfg.block3TextSelect);
		// every combine method, then a surplus byte that must be ignored
		for (int m = 0; m < 4; m++)
		begin
			lcs_host_model_inst.host_write(1'b1, CMD_OVERLAY);
			lcs_host_model_inst.host_write(1'b0, 8'h08 | 8'(m));
			check_val("combine", 16'(m), scrollCfg.combineMethod);
		end
		lcs_host_model_inst.host_write(1'b0, 8'h04);
		check_val("combine", 3, scrollCfg.combineMethod);
		check_val("blk1Text", 0, scrollCfg.block1TextSelect);
		check_val("blk3Text", 1, scrollCfg.block3TextSelect);
		// layer clear through memory writes leaves the configuration alone
		lcs_host_model_inst.host_write(1'b1, 8'h42);
		lcs_host_model_inst.host_write(1'b0, 8'h20);
		lcs_host_model_inst.host_write(1'b0, 8'h00);
		check_val("activeCmd", 16'h42, activeCmd);
		check_val("hshift", 5, scrollCfg.pixelHshift);
		check_val("blk1Start", 16'h1234, scrollCfg.block1Start);
		// restarted groups: one low byte only, a shift wider than three bits
		lcs_host_model_inst.host_write(1'b1, CMD_SCROLL);
		lcs_host_model_inst.host_write(1'b0, 8'h99);
		check_val("blk1Start", 16'h1299, scrollCfg.block1Start);
		check_val("blk1Lines", 16'h40, scrollCfg.block1Lines);
		lcs_host_model_inst.host_write(1'b1, CMD_HSHIFT);
		lcs_host_model_inst.host_write(1'b0, 8'hff);
		check_val("hshift", 7, scrollCfg.pixelHshift);
		lcs_host_model_inst.host_write(1'b1, CMD_SYS_SETUP);
		lcs_host_model_inst.host_write(1'b0, 8'h38);
		check_val("romSel", 0, sysCfg.charRomSelect);
		check_val("twoPanel", 1, sysCfg.twoPanelDrive);
		check_val("cellWidth", 7, sysCfg.charCellWidth);
		// clock enable low: a whole command and parameter pass unseen
		ce <= 1'b0;
		lcs_host_model_inst.host_write(1'b1, CMD_OVERLAY);
		lcs_host_model_inst.host_write(1'b0, 8'h00);
		ce <= 1'b1;
		repeat (6) @(posedge mclk);
		check_val("combine", 3, scrollCfg.combineMethod);
		check_val("activeCmd", 16'h40, activeCmd);
		// reads: select high returns display data, select low leaves the bus alone
		lcs_host_model_inst.host_read(1'b1, readValue, readDriven);
		check_val("readDriven", 1, readDriven);
		check_val("readData", 16'ha5, readValue);
		lcs_host_model_inst.host_read(1'b0, readValue, readDriven);
		check_val("readDriven", 0, readDriven);
		// second reset in mid-run clears the configuration
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		check_wide("sysCfg", '0, 128'(sysCfg));
		check_wide("scrollCfg", '0, 128'(scrollCfg));
		check_val("activeCmd", 0, activeCmd);
		check_val("oeN", 1, hostDataOeN);
		rst <= 1'b0;
		@(posedge mclk);
		lcs_host_model_inst.host_write(1'b1, CMD_HSHIFT);
		lcs_host_model_inst.host_write(1'b0, 8'h02);
		check_val("hshift", 2, scrollCfg.pixelHshift);
		report_and_stop();
	end

endmodule : testbench
